// file: common/iodl_defs.svh
`ifndef IODL_DEFS_SVH
`define IODL_DEFS_SVH

// i/o space is 64 kbyte, memory space is 4 gbyte
`define IODL_IO_ADDR_BITS 16
`define IODL_DIRECT_PORT_HI 8'h00

// peripheral map inside the 64 kbyte i/o space
`define IODL_BYTE_BASE 16'h0080
`define IODL_PAIR_BASE 16'h0090
`define IODL_HALF_BASE 16'h00a0
`define IODL_WORD_BASE 16'h00b0
`define IODL_DWORD_BASE 16'h00c0
`define IODL_NARROW_BASE 16'h0100
`define IODL_MEM_ALIAS_HI 16'hfe00

// last wait count; the peripheral wait state lasts this many core clocks plus one
`define IODL_WAIT_STATES 3'h3

`endif

// file: common/iodl_pkg.sv
package iodl_pkg;

    typedef enum logic [1:0] {
        IODL_SZ_BYTE = 2'h0,
        IODL_SZ_WORD = 2'h1,
        IODL_SZ_DWORD = 2'h2
    } iodl_size_t;

    typedef enum logic [2:0] {
        IODL_P_IDLE = 3'h1,
        IODL_P_WAIT = 3'h2,
        IODL_P_HOLD = 3'h4
    } iodl_pstate_t;

    typedef enum logic [4:0] {
        IODL_D_IDLE = 5'h01,
        IODL_D_WAIT = 5'h02,
        IODL_D_NISSUE = 5'h04,
        IODL_D_NCAP = 5'h08,
        IODL_D_DONE = 5'h10
    } iodl_dstate_t;

endpackage

// file: common/iodl_bus_if.sv
`timescale 1ns/10ps
interface iodl_bus_if;
    logic [31:2] addr_hi;
    logic lane0_enable_n;
    logic lane1_enable_n;
    logic lane2_enable_n;
    logic lane3_enable_n;
    logic mem_cycle;
    logic write_cycle;
    logic cycle_start;
    logic [31:0] data_wr;
    logic [31:0] data_rd;
    logic cycle_done;
    logic half_width_bus_request_n;

    modport proc_mp (
        output addr_hi, lane0_enable_n, lane1_enable_n, lane2_enable_n, lane3_enable_n,
        output mem_cycle, write_cycle, cycle_start, data_wr,
        input data_rd, cycle_done, half_width_bus_request_n
    );

    modport dec_mp (
        input addr_hi, lane0_enable_n, lane1_enable_n, lane2_enable_n, lane3_enable_n,
        input mem_cycle, write_cycle, cycle_start, data_wr,
        output data_rd, cycle_done, half_width_bus_request_n
    );
endinterface

// file: src/iodl_proc_end.sv
`timescale 1ns/10ps
`include "iodl_defs.svh"
module iodl_proc_end (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_req,
    input wire logic i_mem,
    input wire logic i_write,
    input wire iodl_pkg::iodl_size_t i_size,
    input wire logic [31:0] i_addr,
    input wire logic i_direct,
    input wire logic [31:0] i_wdata,
    output logic o_busy,
    output logic o_done,
    output logic o_err,
    output logic [31:0] o_rdata,
    iodl_bus_if.proc_mp bus
);

    function automatic logic [3:0] lane_mask(input iodl_pkg::iodl_size_t sz,
                                             input logic [1:0] off);
        logic [3:0] base;
        base = 4'h1;
        case (sz)
            iodl_pkg::IODL_SZ_WORD: base = 4'h3;
            iodl_pkg::IODL_SZ_DWORD: base = 4'hf;
            default: base = 4'h1;
        endcase
        lane_mask = 4'(base << off);
    endfunction

    // upper-only writes also show on d15-d0 for half-width devices
    function automatic logic [31:0] dup_upper(input logic [31:0] d, input logic [3:0] ln,
                                              input logic wr);
        dup_upper = d;
        if (wr && ln[1:0] == 2'h0 && ln[3:2] != 2'h0) begin
            dup_upper = {d[31:16], d[31:16]};
        end
    endfunction

    iodl_pkg::iodl_pstate_t state_r;
    logic [3:0] lanes_r;
    logic [1:0] off_r;
    logic write_r;
    logic [31:0] wdata_r;
    logic [31:0] acc_r;
    logic [1:0] off;
    logic [3:0] mask;
    logic bad;
    logic [31:0] steered;
    logic need_split;
    logic [31:0] rd_src;
    logic [31:0] merged;

    always_comb begin
        off = i_addr[1:0];
        mask = lane_mask(i_size, off);
        // a transfer may not cross a doubleword; i/o ports above 64k do not exist
        bad = (i_size == iodl_pkg::IODL_SZ_WORD && off == 2'h3) ||
              (i_size == iodl_pkg::IODL_SZ_DWORD && off != 2'h0) ||
              (!i_mem && i_addr[31:`IODL_IO_ADDR_BITS] != 16'h0000) ||
              (!i_mem && i_direct && i_addr[15:8] != `IODL_DIRECT_PORT_HI);
        steered = i_wdata << {off, 3'h0};
        need_split = !bus.half_width_bus_request_n && lanes_r[1:0] != 2'h0 &&
                     lanes_r[3:2] != 2'h0;
        // a half-width device returns upper bytes on the lower half
        rd_src = bus.data_rd;
        if (!bus.half_width_bus_request_n && lanes_r[1:0] == 2'h0) begin
            rd_src = {bus.data_rd[15:0], bus.data_rd[15:0]};
        end
        for (int i = 0; i < 4; i++) begin
            merged[i*8 +: 8] = lanes_r[i] ? rd_src[i*8 +: 8] : acc_r[i*8 +: 8];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= iodl_pkg::IODL_P_IDLE;
            lanes_r <= 4'h0;
            off_r <= 2'h0;
            write_r <= 1'b0;
            wdata_r <= 32'h0;
            acc_r <= 32'h0;
        end else begin
            case (state_r)
                iodl_pkg::IODL_P_IDLE: begin
                    if (i_req && !bad) begin
                        lanes_r <= mask;
                        off_r <= off;
                        write_r <= i_write;
                        wdata_r <= steered;
                        acc_r <= 32'h0;
                        state_r <= iodl_pkg::IODL_P_WAIT;
                    end
                end
                iodl_pkg::IODL_P_WAIT: begin
                    if (bus.cycle_done) begin
                        acc_r <= merged;
                        if (need_split) begin
                            lanes_r <= {lanes_r[3:2], 2'h0};
                            state_r <= iodl_pkg::IODL_P_WAIT;
                        end else begin
                            state_r <= iodl_pkg::IODL_P_HOLD;
                        end
                    end
                end
                default: begin
                    state_r <= iodl_pkg::IODL_P_IDLE;
                end
            endcase
        end
    end

    // bus drive: a new cycle starts on accept and again on a half-width split
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bus.addr_hi <= 30'h0;
            {bus.lane3_enable_n, bus.lane2_enable_n} <= 2'h3;
            {bus.lane1_enable_n, bus.lane0_enable_n} <= 2'h3;
            bus.mem_cycle <= 1'b0;
            bus.write_cycle <= 1'b0;
            bus.cycle_start <= 1'b0;
            bus.data_wr <= 32'h0;
        end else begin
            bus.cycle_start <= 1'b0;
            if (state_r == iodl_pkg::IODL_P_IDLE && i_req && !bad) begin
                bus.addr_hi <= i_addr[31:2];
                {bus.lane3_enable_n, bus.lane2_enable_n,
                 bus.lane1_enable_n, bus.lane0_enable_n} <= ~mask;
                bus.mem_cycle <= i_mem;
                bus.write_cycle <= i_write;
                bus.data_wr <= dup_upper(steered, mask, i_write);
                bus.cycle_start <= 1'b1;
            end else if (state_r == iodl_pkg::IODL_P_WAIT && bus.cycle_done && need_split) begin
                {bus.lane1_enable_n, bus.lane0_enable_n} <= 2'h3;
                bus.data_wr <= dup_upper(wdata_r, {lanes_r[3:2], 2'h0}, write_r);
                bus.cycle_start <= 1'b1;
            end else if (state_r == iodl_pkg::IODL_P_HOLD) begin
                {bus.lane3_enable_n, bus.lane2_enable_n} <= 2'h3;
                {bus.lane1_enable_n, bus.lane0_enable_n} <= 2'h3;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_err <= 1'b0;
            o_rdata <= 32'h0;
        end else begin
            o_done <= 1'b0;
            o_err <= 1'b0;
            if (state_r == iodl_pkg::IODL_P_IDLE && i_req) begin
                o_busy <= !bad;
                o_done <= bad;
                o_err <= bad;
            end else if (state_r == iodl_pkg::IODL_P_WAIT && bus.cycle_done && !need_split) begin
                o_busy <= 1'b0;
                o_done <= 1'b1;
                o_rdata <= merged >> {off_r, 3'h0};
            end
        end
    end

endmodule

// file: src/iodl_decode_end.sv
`timescale 1ns/10ps
`include "iodl_defs.svh"
// Contract
// - 64k i/o space beside 4g memory
// - byte address picks its data lane
// - upper-only writes duplicated onto lower half
// - shared doubleword selects include lane enables
// - four-spaced devices ignore lanes, share d7-d0
// - optional memory alias of whole i/o space
// - adjacent 16-bit devices request half width
// - 16-bit within a doubleword (offset 3 refused), 32-bit four-aligned addresses
// - 32-bit select needs all four lanes
// - a2-a15 drive linear selects directly
// - 8-bit bus converter, one lane at a time
// - direct port operand reaches first 256 only
module iodl_decode_end (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_mem_alias_en,
    input wire logic i_linear_en,
    input wire logic [31:0] i_periph_rdata,
    input wire logic [7:0] i_narrow_rdata,
    output logic [3:0] o_cs_byte,
    output logic [1:0] o_cs_pair,
    output logic [1:0] o_cs_half,
    output logic [1:0] o_cs_word,
    output logic o_cs_dword,
    output logic o_cs_narrow,
    output logic [13:0] o_linear_sel,
    output logic [13:0] o_linear_sel_n,
    output logic o_cycle_active,
    output logic o_periph_write,
    output logic [31:0] o_periph_wdata,
    output logic o_narrow_strobe,
    output logic [1:0] o_narrow_lane,
    output logic [7:0] o_narrow_wdata,
    iodl_bus_if.dec_mp bus
);

    // doubleword match; a is a15..a2
    function automatic logic dw_hit(input logic [13:0] a, input logic [15:0] base);
        dw_hit = (a == base[15:2]);
    endfunction

    // 16-byte group match, four doublewords
    function automatic logic grp_hit(input logic [13:0] a, input logic [15:0] base);
        grp_hit = (a[13:2] == base[15:4]);
    endfunction

    function automatic logic [1:0] low_lane(input logic [3:0] p);
        low_lane = 2'h3;
        if (p[0]) begin
            low_lane = 2'h0;
        end else if (p[1]) begin
            low_lane = 2'h1;
        end else if (p[2]) begin
            low_lane = 2'h2;
        end
    endfunction

    iodl_pkg::iodl_dstate_t state_r;
    logic [2:0] wait_cnt_r;
    logic [3:0] pend_r;
    logic [31:0] wdata_r;
    logic [31:0] nacc_r;
    logic [3:0] lanes;
    logic [13:0] a;
    logic io_hit;
    logic [3:0] cs_byte_nxt;
    logic [1:0] cs_pair_nxt;
    logic [1:0] cs_half_nxt;
    logic [1:0] cs_word_nxt;
    logic cs_dword_nxt;
    logic cs_narrow_nxt;
    logic half_nxt;
    logic [1:0] nlane;
    logic [3:0] pend_left;

    always_comb begin
        lanes = ~{bus.lane3_enable_n, bus.lane2_enable_n, bus.lane1_enable_n,
                  bus.lane0_enable_n};
        a = bus.addr_hi[15:2];
        // memory alias answers the same device in a 64k memory window
        io_hit = !bus.mem_cycle ||
                 (i_mem_alias_en && bus.addr_hi[31:16] == `IODL_MEM_ALIAS_HI);
        cs_byte_nxt = 4'h0;
        cs_pair_nxt = 2'h0;
        cs_half_nxt = 2'h0;
        cs_word_nxt = 2'h0;
        cs_dword_nxt = 1'b0;
        cs_narrow_nxt = 1'b0;
        half_nxt = 1'b0;
        if (io_hit) begin
            if (grp_hit(a, `IODL_BYTE_BASE)) begin
                cs_byte_nxt = 4'(4'h1 << a[1:0]);
            end else if (dw_hit(a, `IODL_PAIR_BASE)) begin
                cs_pair_nxt = lanes[1:0];
            end else if (dw_hit(a, `IODL_HALF_BASE)) begin
                cs_half_nxt = {|lanes[3:2], |lanes[1:0]};
                half_nxt = 1'b1;
            end else if (grp_hit(a, `IODL_WORD_BASE) && !a[1]) begin
                // one 16-bit device per doubleword needs no half-width cycle
                cs_word_nxt = a[0] ? 2'h2 : 2'h1;
            end else if (dw_hit(a, `IODL_DWORD_BASE)) begin
                cs_dword_nxt = (lanes == 4'hf);
            end else if (a[13:6] == 8'(`IODL_NARROW_BASE >> 8)) begin
                cs_narrow_nxt = 1'b1;
            end
        end
        nlane = low_lane(pend_r);
        pend_left = pend_r & ~(4'(4'h1 << nlane));
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= iodl_pkg::IODL_D_IDLE;
            wait_cnt_r <= 3'h0;
            pend_r <= 4'h0;
        end else begin
            case (state_r)
                iodl_pkg::IODL_D_IDLE: begin
                    wait_cnt_r <= 3'h0;
                    if (bus.cycle_start) begin
                        pend_r <= lanes;
                        if (cs_narrow_nxt && lanes != 4'h0) begin
                            state_r <= iodl_pkg::IODL_D_NISSUE;
                        end else begin
                            state_r <= iodl_pkg::IODL_D_WAIT;
                        end
                    end
                end
                iodl_pkg::IODL_D_WAIT: begin
                    wait_cnt_r <= wait_cnt_r + 3'h1;
                    if (wait_cnt_r == `IODL_WAIT_STATES) begin
                        state_r <= iodl_pkg::IODL_D_DONE;
                    end
                end
                iodl_pkg::IODL_D_NISSUE: begin
                    state_r <= iodl_pkg::IODL_D_NCAP;
                end
                iodl_pkg::IODL_D_NCAP: begin
                    pend_r <= pend_left;
                    state_r <= (pend_left == 4'h0) ? iodl_pkg::IODL_D_DONE :
                               iodl_pkg::IODL_D_NISSUE;
                end
                default: begin
                    state_r <= iodl_pkg::IODL_D_IDLE;
                end
            endcase
        end
    end

    // selects are taken once at cycle start and kept until the done beat ends
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cs_byte <= 4'h0;
            o_cs_pair <= 2'h0;
            o_cs_half <= 2'h0;
            o_cs_word <= 2'h0;
            o_cs_dword <= 1'b0;
            o_cs_narrow <= 1'b0;
            o_linear_sel <= 14'h0;
            o_linear_sel_n <= 14'h3fff;
            o_cycle_active <= 1'b0;
            o_periph_write <= 1'b0;
            o_periph_wdata <= 32'h0;
            wdata_r <= 32'h0;
            bus.half_width_bus_request_n <= 1'b1;
        end else if (state_r == iodl_pkg::IODL_D_IDLE && bus.cycle_start) begin
            o_cs_byte <= cs_byte_nxt;
            o_cs_pair <= cs_pair_nxt;
            o_cs_half <= cs_half_nxt;
            o_cs_word <= cs_word_nxt;
            o_cs_dword <= cs_dword_nxt;
            o_cs_narrow <= cs_narrow_nxt;
            // linear selects exist only in i/o space; mixed polarity offered both ways
            o_linear_sel <= (i_linear_en && !bus.mem_cycle) ? a : 14'h0;
            o_linear_sel_n <= (i_linear_en && !bus.mem_cycle) ? ~a : 14'h3fff;
            o_cycle_active <= 1'b1;
            o_periph_write <= bus.write_cycle;
            o_periph_wdata <= bus.data_wr;
            wdata_r <= bus.data_wr;
            bus.half_width_bus_request_n <= !half_nxt;
        end else if (state_r == iodl_pkg::IODL_D_DONE) begin
            o_cs_byte <= 4'h0;
            o_cs_pair <= 2'h0;
            o_cs_half <= 2'h0;
            o_cs_word <= 2'h0;
            o_cs_dword <= 1'b0;
            o_cs_narrow <= 1'b0;
            o_linear_sel <= 14'h0;
            o_linear_sel_n <= 14'h3fff;
            o_cycle_active <= 1'b0;
            o_periph_write <= 1'b0;
            bus.half_width_bus_request_n <= 1'b1;
        end
    end

    // narrow converter: one byte lane on the 8-bit bus per step
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_narrow_strobe <= 1'b0;
            o_narrow_lane <= 2'h0;
            o_narrow_wdata <= 8'h0;
            nacc_r <= 32'h0;
        end else begin
            o_narrow_strobe <= 1'b0;
            if (state_r == iodl_pkg::IODL_D_IDLE) begin
                nacc_r <= 32'h0;
            end else if (state_r == iodl_pkg::IODL_D_NISSUE) begin
                o_narrow_strobe <= 1'b1;
                o_narrow_lane <= nlane;
                o_narrow_wdata <= wdata_r[{nlane, 3'h0} +: 8];
            end else if (state_r == iodl_pkg::IODL_D_NCAP) begin
                nacc_r[{o_narrow_lane, 3'h0} +: 8] <= i_narrow_rdata;
            end
        end
    end

    // answer: one-cycle done; read data sits on the lanes of the request
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bus.cycle_done <= 1'b0;
            bus.data_rd <= 32'h0;
        end else begin
            bus.cycle_done <= 1'b0;
            if (state_r == iodl_pkg::IODL_D_WAIT && wait_cnt_r == `IODL_WAIT_STATES) begin
                bus.cycle_done <= 1'b1;
                bus.data_rd <= i_periph_rdata;
            end else if (state_r == iodl_pkg::IODL_D_NCAP && pend_left == 4'h0) begin
                bus.cycle_done <= 1'b1;
                bus.data_rd <= nacc_r;
                bus.data_rd[{o_narrow_lane, 3'h0} +: 8] <= i_narrow_rdata;
            end
        end
    end

endmodule

// file: dv/iodl_bus_props.sv
`timescale 1ns/10ps
module iodl_bus_props (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic [31:2] addr_hi,
    input wire logic lane0_enable_n,
    input wire logic lane1_enable_n,
    input wire logic lane2_enable_n,
    input wire logic lane3_enable_n,
    input wire logic mem_cycle,
    input wire logic write_cycle,
    input wire logic cycle_start,
    input wire logic [31:0] data_wr,
    input wire logic [31:0] data_rd,
    input wire logic cycle_done,
    input wire logic half_width_bus_request_n
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    logic in_cycle_r;
    logic [3:0] lanes_n;
    assign lanes_n = {lane3_enable_n, lane2_enable_n, lane1_enable_n, lane0_enable_n};
    // tracks start..done so held levels can be judged without knowing the wait count
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            in_cycle_r <= 1'b0;
        end else if (cycle_start) begin
            in_cycle_r <= 1'b1;
        end else if (cycle_done) begin
            in_cycle_r <= 1'b0;
        end
    end
    a_io_range_limit: assert property (cycle_start && !mem_cycle |->
        addr_hi[31:16] == 16'h0000)
        else $error("i/o cycle beyond 64k");
    a_lane_pattern: assert property (cycle_start |->
        lanes_n inside {4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h9, 4'h3, 4'h0})
        else $error("illegal lane enable pattern");
    a_upper_copy: assert property (cycle_start && write_cycle && lanes_n[1:0] == 2'h3
        |-> data_wr[15:0] == data_wr[31:16])
        else $error("upper write data not copied low");
    a_addr_held: assert property (in_cycle_r && !cycle_start |-> $stable(addr_hi)
        && $stable(lanes_n) && $stable(write_cycle) && $stable(mem_cycle))
        else $error("cycle qualifiers moved");
    a_no_overlap: assert property (in_cycle_r && !cycle_done |-> !cycle_start)
        else $error("new cycle inside open cycle");
    a_done_bound: assert property (cycle_start |-> ##[1:20] cycle_done)
        else $error("cycle never completed");
    a_rd_update: assert property (!$stable(data_rd) |-> cycle_done)
        else $error("read data moved without done");
    a_hw_idle: assert property (!in_cycle_r && !cycle_start |-> half_width_bus_request_n)
        else $error("half width request outside cycle");
    a_hw_held: assert property (in_cycle_r && $past(in_cycle_r)
        |-> $stable(half_width_bus_request_n))
        else $error("half width request moved");
    c_upper_write: cover property (cycle_start && write_cycle && lanes_n == 4'h3);
    c_half_width: cover property (cycle_done && !half_width_bus_request_n);
    c_dword_read: cover property (cycle_start && !write_cycle && lanes_n == 4'h0);
endmodule

// file: dv/io_address_decode_lanes_tb.sv
`timescale 1ns/10ps
module io_address_decode_lanes_tb;
    logic i_core_clk, i_reset_n, i_req, i_mem, i_write, i_direct, o_busy, o_done, o_err;
    iodl_pkg::iodl_size_t i_size;
    logic [31:0] i_addr, i_wdata, o_rdata, i_periph_rdata, o_periph_wdata, wd_s;
    logic i_mem_alias_en, i_linear_en, o_cs_dword, o_cs_narrow, o_cycle_active;
    logic o_periph_write, o_narrow_strobe, hw_acc, first;
    logic [7:0] i_narrow_rdata, o_narrow_wdata;
    logic [3:0] o_cs_byte, lanes_s, nstb;
    logic [1:0] o_cs_pair, o_cs_half, o_cs_word, o_narrow_lane;
    logic [13:0] o_linear_sel, o_linear_sel_n, lin_acc;
    logic [11:0] sel_acc;
    typedef struct {logic err; logic rd; logic [31:0] rdata; logic [11:0] sel; logic [13:0] lin;
        logic hw; logic [3:0] lanes; logic wchk; logic [31:0] wd; logic [3:0] nstb;} iodl_tb_exp_t;
    iodl_tb_exp_t exp_q[$];
    iodl_tb_exp_t m;
    int n_fail = 0, n_tests = 0, cycles = 0;
    integer seed = 32'h3f13fc0b;
    // narrow bus answers with a lane-tagged byte so the assembly order is visible
    assign i_narrow_rdata = 8'ha0 + {6'h00, o_narrow_lane};
    iodl_bus_if bus_if_i ();
    iodl_proc_end iodl_proc_end_i (.i_core_clk, .i_reset_n, .i_req, .i_mem, .i_write, .i_size,
        .i_addr, .i_direct, .i_wdata, .o_busy, .o_done, .o_err, .o_rdata, .bus(bus_if_i));
    iodl_decode_end iodl_decode_end_i (.i_core_clk, .i_reset_n, .i_mem_alias_en, .i_linear_en,
        .i_periph_rdata, .i_narrow_rdata, .o_cs_byte, .o_cs_pair, .o_cs_half, .o_cs_word,
        .o_cs_dword, .o_cs_narrow, .o_linear_sel, .o_linear_sel_n, .o_cycle_active,
        .o_periph_write, .o_periph_wdata, .o_narrow_strobe, .o_narrow_lane, .o_narrow_wdata,
        .bus(bus_if_i));
    iodl_bus_props iodl_bus_props_i (.i_core_clk, .i_reset_n, .addr_hi(bus_if_i.addr_hi),
        .lane0_enable_n(bus_if_i.lane0_enable_n), .lane1_enable_n(bus_if_i.lane1_enable_n),
        .lane2_enable_n(bus_if_i.lane2_enable_n), .lane3_enable_n(bus_if_i.lane3_enable_n),
        .mem_cycle(bus_if_i.mem_cycle), .write_cycle(bus_if_i.write_cycle),
        .cycle_start(bus_if_i.cycle_start), .data_wr(bus_if_i.data_wr),
        .data_rd(bus_if_i.data_rd), .cycle_done(bus_if_i.cycle_done),
        .half_width_bus_request_n(bus_if_i.half_width_bus_request_n));
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            end_sim();
        end
    end
    // kind: 0 wide, 1 narrow bus, 2 split half width, 3 read data not judged
    task automatic xfer(input logic mem, input logic wr, input iodl_pkg::iodl_size_t sz,
        input logic [31:0] a, input logic dir, input logic [1:0] kind, input logic err,
        input logic [11:0] sel, input logic [13:0] lin, input logic hw);
        iodl_tb_exp_t e;
        logic [31:0] wdat, prd, mask;
        int nb, k, w;
        nb = (sz == iodl_pkg::IODL_SZ_BYTE) ? 1 : (sz == iodl_pkg::IODL_SZ_WORD) ? 2 : 4;
        k = a[1:0];
        mask = (nb == 4) ? 32'hffffffff : (32'h1 << (8 * nb)) - 32'h1;
        wdat = $random(seed) & mask;
        prd = $random(seed);
        e.err = err; e.sel = sel; e.lin = lin; e.hw = hw;
        e.rd = !wr && kind != 2'h3 && !err;
        e.lanes = ~(4'((1 << nb) - 1) << k);
        e.wchk = wr && !err;
        e.wd = wdat << (8 * k);
        if (e.lanes[1:0] == 2'h3) e.wd[15:0] = e.wd[31:16];
        e.rdata = (prd >> (8 * k)) & mask;
        if (kind == 2'h2) e.rdata = {prd[15:0], prd[15:0]};
        e.nstb = (kind == 2'h1) ? 4'(nb) : 4'h0;
        if (kind == 2'h1) for (w = 0; w < nb; w++) e.rdata[8*w +: 8] = 8'ha0 + 8'(k + w);
        @(posedge i_core_clk);
        #1 i_periph_rdata = prd;
        i_req = 1'b1; i_mem = mem; i_write = wr; i_size = sz; i_addr = a; i_direct = dir;
        i_wdata = wdat;
        exp_q.push_back(e);
        @(posedge i_core_clk);
        #1;
        i_req = 1'b0;
        w = 0;
        while (o_done !== 1'b1 && w < 100) begin
            @(posedge i_core_clk);
            #1 w++;
        end
    endtask
    always @(posedge i_core_clk) begin
        if (i_reset_n !== 1'b1) begin
            sel_acc = 0; lin_acc = 0; hw_acc = 0; nstb = 0; first = 1; lanes_s = 0; wd_s = 0;
        end else begin
            if (bus_if_i.cycle_start === 1'b1 && first) begin
                lanes_s = {bus_if_i.lane3_enable_n, bus_if_i.lane2_enable_n,
                    bus_if_i.lane1_enable_n, bus_if_i.lane0_enable_n};
                wd_s = bus_if_i.data_wr;
                first = 0;
            end
            if (bus_if_i.cycle_done === 1'b1) begin
                sel_acc |= {o_cs_byte, o_cs_pair, o_cs_half, o_cs_word, o_cs_dword, o_cs_narrow};
                lin_acc |= o_linear_sel;
                hw_acc |= !bus_if_i.half_width_bus_request_n;
                chk(o_linear_sel_n, {18'h0, ~o_linear_sel}, "select polarity");
            end
            if (o_narrow_strobe === 1'b1) nstb++;
            if (o_done === 1'b1 && exp_q.size() > 0) begin
                m = exp_q.pop_front();
                chk(o_err, m.err, "refusal");
                if (m.rd) chk(o_rdata, m.rdata, "read data");
                chk(sel_acc, m.sel, "selects");
                chk(lin_acc, m.lin, "linear selects");
                chk(hw_acc, m.hw, "half width");
                chk(nstb, m.nstb, "narrow strobes");
                if (!m.err) chk(lanes_s, m.lanes, "lane enables");
                if (m.wchk) chk(wd_s, m.wd, "write data");
                sel_acc = 0; lin_acc = 0; hw_acc = 0; nstb = 0; first = 1;
            end
        end
    end
    initial begin
        int i;
        i_reset_n = 0; i_req = 0; i_mem = 0; i_write = 0; i_size = iodl_pkg::IODL_SZ_BYTE;
        i_addr = 0; i_direct = 0; i_wdata = 0; i_periph_rdata = 0;
        i_mem_alias_en = 0; i_linear_en = 0;
        repeat (6) @(posedge i_core_clk);
        #1 i_reset_n = 1;
        for (i = 0; i < 4; i++) xfer(0, 0, iodl_pkg::IODL_SZ_BYTE, 32'h80 + 4 * i, i == 0, 0, 0,
            12'h100 << i, 0, 0);
        for (i = 0; i < 4; i++) xfer(0, 1, iodl_pkg::IODL_SZ_BYTE, 32'hc0 + i, 0, 3, 0, 0,
            0, 0);
        for (i = 0; i < 2; i++) xfer(0, 1, iodl_pkg::IODL_SZ_BYTE, 32'h90 + i, 0, 0, 0,
            12'h040 << i, 0, 0);
        for (i = 0; i < 2; i++) xfer(0, 1, iodl_pkg::IODL_SZ_WORD, 32'ha0 + 2 * i, 0, 0, 0,
            12'h010 << i, 0, 1);
        for (i = 0; i < 2; i++) xfer(0, i[0], iodl_pkg::IODL_SZ_DWORD, 32'ha0, 0, 2, 0,
            12'h030, 0, 1);
        for (i = 0; i < 2; i++) xfer(0, 0, iodl_pkg::IODL_SZ_WORD, 32'hb0 + 4 * i, 0, 0, 0,
            12'h004 << i, 0, 0);
        xfer(0, 0, iodl_pkg::IODL_SZ_DWORD, 32'hc0, 0, 0, 0, 12'h002, 0, 0);
        xfer(0, 0, iodl_pkg::IODL_SZ_WORD, 32'h100, 0, 1, 0, 12'h001, 0, 0);
        xfer(0, 0, iodl_pkg::IODL_SZ_DWORD, 32'h100, 0, 1, 0, 12'h001, 0, 0);
        xfer(0, 1, iodl_pkg::IODL_SZ_BYTE, 32'h103, 0, 1, 0, 12'h001, 0, 0);
        xfer(0, 0, iodl_pkg::IODL_SZ_WORD, 32'h83, 0, 0, 1, 0, 0, 0);
        xfer(0, 0, iodl_pkg::IODL_SZ_DWORD, 32'h82, 0, 0, 1, 0, 0, 0);
        xfer(0, 0, iodl_pkg::IODL_SZ_BYTE, 32'h10000, 0, 0, 1, 0, 0, 0);
        xfer(0, 0, iodl_pkg::IODL_SZ_BYTE, 32'h100, 1, 0, 1, 0, 0, 0);
        xfer(0, 0, iodl_pkg::IODL_SZ_BYTE, 32'hfc, 1, 3, 0, 0, 0, 0);
        for (i = 0; i < 2; i++) begin
            i_mem_alias_en = i[0];
            xfer(1, 0, iodl_pkg::IODL_SZ_BYTE, 32'hfe000084, 0, i ? 0 : 3, 0,
                i ? 12'h200 : 12'h000, 0, 0);
        end
        i_mem_alias_en = 0;
        i_linear_en = 1;
        xfer(0, 0, iodl_pkg::IODL_SZ_BYTE, 32'h10, 0, 3, 0, 0, 14'h0004, 0);
        xfer(0, 1, iodl_pkg::IODL_SZ_BYTE, 32'h8000, 0, 3, 0, 0, 14'h2000, 0);
        i_linear_en = 0;
        // second reset while idle: idle levels must come back without a clock edge
        @(posedge i_core_clk);
        #1 i_reset_n = 0;
        #1;
        chk(o_busy, 0, "busy in reset");
        chk(bus_if_i.half_width_bus_request_n, 1, "half width in reset");
        chk(o_linear_sel_n, 32'h3fff, "linear idle");
        @(posedge i_core_clk);
        #1 i_reset_n = 1;
        xfer(0, 0, iodl_pkg::IODL_SZ_BYTE, 32'h8c, 0, 0, 0, 12'h800, 0, 0);
        @(posedge i_core_clk);
        #1 chk(exp_q.size(), 0, "results missing");
        end_sim();
    end
endmodule
